/* File: spm_cfg.svh */
// Purpose: Offsets, field positions, reset values and counts of the serial port
// Assumes: Byte addresses on a 32-bit address bus, registers in low data bits
// Notes: Definitions only
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

`define SPM_OFS_STATUS 32'hffff0a00
`define SPM_OFS_RECEIVE 32'hffff0a04
`define SPM_OFS_TRANSMIT 32'hffff0a08
`define SPM_OFS_DIVIDER 32'hffff0a0c
`define SPM_OFS_CONTROL 32'hffff0a10

`define SPM_CTL_EN 0
`define SPM_CTL_MASTER 1
`define SPM_CTL_CPHA 2
`define SPM_CTL_CPOL 3
`define SPM_CTL_LSB 5
`define SPM_CTL_TRIG 6
`define SPM_CTL_UNDREP 7
`define SPM_CTL_OVWR 8
`define SPM_CTL_SSOUT 9
`define SPM_CTL_SOUT 10
`define SPM_CTL_MASK 16'h07ef

`define SPM_ST_BUSY 0
`define SPM_ST_TXIRQ 1
`define SPM_ST_UND 2
`define SPM_ST_RXFULL 3
`define SPM_ST_RXIRQ 4
`define SPM_ST_OVF 5

`define SPM_CTL_RST 16'h0000
`define SPM_STA_RST 8'h00
`define SPM_RX_RST 8'h00
`define SPM_TX_RST 8'h00
`define SPM_DIV_RST 8'h1b

`define SPM_LAST_HALF 4'hf
`define SPM_LAST_BIT 3'h7

`endif

/* File: spm_peer.sv */
// Purpose: Far-side slave for master transfers
// Assumes: Mode and bit order set by the bench
// Notes: A released data line shows the inverse of its last value
`timescale 1ns/100ps
module spm_peer (
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic lsb_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  logic ps = 1'b0;
  logic pss = 1'b1;
  int n = 0;
  function automatic int pos(input int k);
    return lsb_i ? k : 7 - k;
  endfunction
  initial miso_o = 1'b0;
  initial rx_o = 8'h00;
  // One process for both lines, so a select edge and a clock edge in one step keep order
  always @(sclk_i, ss_n_i) begin
    if (ss_n_i && !pss) begin
      miso_o = ~miso_o;
    end
    if (!ss_n_i && pss) begin
      n = 0;
      miso_o = tx_i[pos(0)];
    end
    if (!ss_n_i && sclk_i !== ps && n < 8) begin
      if (sclk_i === ~(cpol_i ^ cpha_i)) begin
        rx_o[pos(n)] = mosi_i;
        n++;
      end else begin
        miso_o = tx_i[pos(n)];
      end
    end
    ps = sclk_i;
    pss = ss_n_i;
  end
endmodule

/* File: spm_pkg.sv */
// Purpose: Types shared by the serial port design
// Assumes: Nothing beyond SystemVerilog
// Notes: Master sequencer states are coded 0, 1 and 3; the return to idle flips two bits
package spm_pkg;
  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_RUN = 2'h1,
    M_END = 2'h3
  } spm_state_type;
endpackage

/* File: spm_port.sv */
// Purpose: Byte-wide serial port, master or slave, with a simple register port
// Assumes: Serial clock derived from ref_clk_i; pins pass two flip-flops
// Notes: Divider gives a half period of (1 + divider) reference cycles
`timescale 1ns/100ps
`include "spm_cfg.svh"

// Behaviour
// (R1) Trigger bit set, master: transmit write starts transfer; interrupt when empty.
// (R2) Trigger bit clear, master: receive read starts transfer; interrupt when full.
// (R3) Bit-order bit set sends LSB first, clear sends MSB first.
// (R4) Polarity bit sets serial clock idle level high, clear sets low.
// (R5) Phase bit set pulses clock at bit start, clear at bit end.
// (R6) Master bit set drives clock and data out; clear makes a slave.
// (R7) Whole port works only while enable bit is set.
// (R8) Software writes zero to the reserved control bit four.
// (R9) Underflow mode clear and no new byte: zeros are shifted out.
// (R10) Overflow flag sets on arrival into unread data; read clears it.
// (R11) Receive interrupt flag follows full or overflow; read clears it.
// (R12) Receive-full flag sets with valid data; read of receive clears.
// (R13) Underflow flag sets when transfer lacks a byte; transmit write clears.
// (R14) Transmit interrupt sets when idle or underflow; write or disable clears; a disable while busy keeps it.
// (R15) Busy sets on transmit write, holds while shifting, clears when empty.
// (R16) Receive register holds last received byte, resets to zero.
// (R17) Transmit register write loads the byte to shift out.
// (R18) Divider register sets serial clock rate, resets to its default.
// (R19) Status register shows transmit and receive state, resets zero.
// (R20) Underflow mode set and no new byte: previous byte is resent.
// (R21) Master clock is reference clock over two times one plus divider.
// (R22) On overflow, overwrite bit keeps new byte, otherwise new byte dropped.
// (R23) External master frames slave transfers with active-low select.
// (R24) Reset clears flags and abandons any transfer in progress.
module spm_port (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [31:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe_o,
  output spm_pkg::spm_state_type state_o
);
  import spm_pkg::*;

  logic [15:0] ctl_r;
  logic [7:0] div_r;
  logic [7:0] tx_data_r;
  logic [7:0] rx_data_r;
  logic [7:0] last_r;
  logic [7:0] tsh_r;
  logic [7:0] rsh_r;
  logic [15:0] rdata_r;
  logic tx_full_r, busy_r, und_r, txirq_r, rx_full_r, ovf_r, rxirq_r;
  logic busy_nxt, und_nxt, txirq_nxt, rx_full_nxt, ovf_nxt;
  logic rd_pend_r;
  spm_state_type state_r;
  logic [3:0] half_r;
  logic [3:0] half_nxt;
  logic [7:0] cnt_r;
  logic tick;
  logic sclk_r, ss_out_r;
  logic [1:0] sclk_s, mosi_s, miso_s, ss_s;
  logic sclk_d_r, ss_d_r;
  logic [2:0] bit_r;
  logic skip_r, reload_r;
  logic en, master, cpha, cpol, lsb, trig;
  logic wr_tx, wr_ctl, wr_div, rd_rx;
  logic m_start, m_done, s_act, s_fall, s_lead, s_trail, s_sample, s_change;
  logic load_ev, deliver, done_ev, serial_in, en_fall;
  logic [7:0] rx_byte;

  assign en = ctl_r[`SPM_CTL_EN];
  assign master = ctl_r[`SPM_CTL_MASTER];
  assign cpha = ctl_r[`SPM_CTL_CPHA];
  assign cpol = ctl_r[`SPM_CTL_CPOL];
  assign lsb = ctl_r[`SPM_CTL_LSB];
  assign trig = ctl_r[`SPM_CTL_TRIG];

  assign wr_tx = wr_i && addr_i == `SPM_OFS_TRANSMIT;
  assign wr_ctl = wr_i && addr_i == `SPM_OFS_CONTROL;
  assign wr_div = wr_i && addr_i == `SPM_OFS_DIVIDER;
  assign rd_rx = rd_i && addr_i == `SPM_OFS_RECEIVE;

  // Pin synchronisers; only stage 1 is read by logic
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_s <= 2'h0;
      mosi_s <= 2'h0;
      miso_s <= 2'h0;
      ss_s <= 2'h3;
    end else begin
      sclk_s <= {sclk_s[0], sclk_i};
      mosi_s <= {mosi_s[0], mosi_i};
      miso_s <= {miso_s[0], miso_i};
      ss_s <= {ss_s[0], ss_n_i};
    end
  end

  // Control and divider registers
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_r <= `SPM_CTL_RST;
      div_r <= `SPM_DIV_RST; // R18
    end else begin
      if (wr_ctl) begin
        ctl_r <= wdata_i & `SPM_CTL_MASK; // R8
      end
      if (wr_div) begin
        div_r <= wdata_i[7:0]; // R18
      end
    end
  end

  // Half-period enable from the divider
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= 8'h00;
    end else if (state_r != M_RUN || tick) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign tick = state_r == M_RUN && cnt_r >= div_r; // R21

  // Master sequencer
  assign m_start = en && master && state_r == M_IDLE && (trig ? tx_full_r : rd_pend_r); // R1 R2
  assign m_done = state_r == M_RUN && tick && half_r == `SPM_LAST_HALF;
  assign half_nxt = half_r + 4'h1;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= M_IDLE; // R24
      half_r <= 4'h0;
    end else if (!en || !master) begin
      state_r <= M_IDLE; // R7 R6
      half_r <= 4'h0;
    end else begin
      case (state_r)
        M_IDLE: begin
          half_r <= 4'h0;
          if (m_start) begin
            state_r <= M_RUN;
          end
        end
        M_RUN: begin
          if (m_done) begin
            state_r <= M_END;
          end else if (tick) begin
            half_r <= half_nxt;
          end
        end
        M_END: begin
          state_r <= M_IDLE;
        end
        default: begin
          state_r <= M_IDLE;
        end
      endcase
    end
  end
  assign state_o = state_r;

  // Clock active in odd halves for phase clear, even halves for phase set
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_r <= 1'b0;
      ss_out_r <= 1'b1;
    end else if (m_start) begin
      sclk_r <= cpol ^ cpha; // R5
      ss_out_r <= 1'b0;
    end else if (state_r == M_RUN && tick && !m_done) begin
      sclk_r <= cpol ^ (half_nxt[0] ^ cpha); // R5
    end else if (state_r != M_RUN) begin
      sclk_r <= cpol; // R4
      ss_out_r <= 1'b1;
    end
  end

  // Read-triggered start request
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_pend_r <= 1'b0;
    end else if (rd_rx && en && master && !trig) begin
      rd_pend_r <= 1'b1; // R2
    end else if (m_start || !en || trig) begin
      rd_pend_r <= 1'b0;
    end
  end

  // Slave edge detection on synchronised pins
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_d_r <= 1'b0;
      ss_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s[1];
      ss_d_r <= ss_s[1];
    end
  end
  assign s_act = en && !master && !ss_s[1]; // R23
  assign s_fall = s_act && ss_d_r;
  assign s_lead = s_act && !s_fall && sclk_s[1] != cpol && sclk_d_r == cpol;
  assign s_trail = s_act && !s_fall && sclk_s[1] == cpol && sclk_d_r != cpol;
  assign s_sample = cpha ? s_trail : s_lead; // R5
  assign s_change = cpha ? s_lead : s_trail;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_r <= 3'h0;
      skip_r <= 1'b0;
      reload_r <= 1'b0;
    end else if (!s_act) begin
      bit_r <= 3'h0;
      skip_r <= 1'b0;
      reload_r <= 1'b0;
    end else if (s_fall) begin
      bit_r <= 3'h0;
      skip_r <= cpha; // First leading edge presents bit 0, no shift
      reload_r <= 1'b0;
    end else begin
      if (s_sample) begin
        bit_r <= bit_r + 3'h1;
        if (bit_r == `SPM_LAST_BIT) begin
          reload_r <= 1'b1;
        end
      end else if (s_change) begin
        skip_r <= 1'b0;
        reload_r <= 1'b0;
      end
    end
  end

  // Shift events shared by both modes
  assign load_ev = m_start || s_fall || (s_change && reload_r);
  assign deliver = m_done || (s_sample && bit_r == `SPM_LAST_BIT);
  assign done_ev = deliver;
  assign serial_in = master ? miso_s[1] : mosi_s[1];
  assign rx_byte = lsb ? {serial_in, rsh_r[7:1]} : {rsh_r[6:0], serial_in};

  // Transmit shifter and held byte
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tsh_r <= `SPM_TX_RST;
      last_r <= `SPM_TX_RST;
    end else if (load_ev) begin
      if (tx_full_r) begin
        tsh_r <= tx_data_r; // R17
        last_r <= tx_data_r;
      end else if (ctl_r[`SPM_CTL_UNDREP]) begin
        tsh_r <= last_r; // R20
      end else begin
        tsh_r <= 8'h00; // R9
      end
    end else if ((state_r == M_RUN && tick && !m_done && !half_nxt[0]) ||
                 (s_change && !skip_r)) begin
      tsh_r <= lsb ? {1'b0, tsh_r[7:1]} : {tsh_r[6:0], 1'b0}; // R3
    end
  end

  // Receive shifter samples on the capture edge
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsh_r <= 8'h00;
    end else if (s_sample || (state_r == M_RUN && tick && !m_done && half_nxt[0])) begin
      rsh_r <= rx_byte; // R3
    end
  end

  // Master samples entering half 15, so the last bit is already in
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_data_r <= `SPM_TX_RST;
      rx_data_r <= `SPM_RX_RST; // R16
    end else begin
      if (wr_tx) begin
        tx_data_r <= wdata_i[7:0]; // R17
      end
      if (deliver && (!rx_full_r || rd_rx || ctl_r[`SPM_CTL_OVWR])) begin
        rx_data_r <= master ? rsh_r : rx_byte; // R16 R22
      end
    end
  end

  // Next status; a hardware set wins over a clearing access, but a disable blocks the transmit interrupt set
  always_comb begin
    // A byte left waiting keeps busy up while disabled; an aborted one does not
    busy_nxt = wr_tx || (busy_r && !(done_ev && !tx_full_r) && (en || tx_full_r)); // R15
    und_nxt = (load_ev && !tx_full_r) || (und_r && !wr_tx); // R13
    txirq_nxt = (en && !en_fall && (!busy_nxt || und_nxt)) ||
                (txirq_r && !wr_tx && !(en_fall && !busy_r)); // R14
    rx_full_nxt = deliver || (rx_full_r && !rd_rx); // R12
    ovf_nxt = (deliver && rx_full_r && !rd_rx) || (ovf_r && !rd_rx); // R10
  end
  assign en_fall = wr_ctl && en && !wdata_i[`SPM_CTL_EN];

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_full_r <= 1'b0; // R24
      busy_r <= 1'b0;
      und_r <= 1'b0;
      txirq_r <= 1'b0;
      rx_full_r <= 1'b0;
      ovf_r <= 1'b0;
      rxirq_r <= 1'b0;
    end else begin
      tx_full_r <= wr_tx || (tx_full_r && !load_ev); // R17
      busy_r <= busy_nxt;
      und_r <= und_nxt;
      txirq_r <= txirq_nxt; // R1
      rx_full_r <= rx_full_nxt;
      ovf_r <= ovf_nxt;
      rxirq_r <= rx_full_nxt || ovf_nxt; // R11 R2
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `SPM_OFS_STATUS: rdata_r <= {10'h000, ovf_r, rxirq_r, rx_full_r, und_r, txirq_r,
                                     busy_r}; // R19
        `SPM_OFS_RECEIVE: rdata_r <= {8'h00, rx_data_r}; // R16
        `SPM_OFS_DIVIDER: rdata_r <= {8'h00, div_r};
        `SPM_OFS_CONTROL: rdata_r <= ctl_r;
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end
  assign rdata_o = rdata_r;

  // Pin drive; master reads miso two cycles late, so divider 2 is the least that works
  assign sclk_o = sclk_r;
  assign sclk_oe_o = en && master; // R6 R7
  assign mosi_o = lsb ? tsh_r[0] : tsh_r[7]; // R3
  assign mosi_oe_o = en && master; // R6
  assign miso_o = lsb ? tsh_r[0] : tsh_r[7];
  assign miso_oe_o = s_act && ctl_r[`SPM_CTL_SOUT];
  assign ss_n_o = ss_out_r;
  assign ss_n_oe_o = en && master && ctl_r[`SPM_CTL_SSOUT];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  chk_clk_idle: assert property ($past(state_r) == M_IDLE && state_r == M_IDLE && en // R4
    && master |-> sclk_o == $past(cpol)) else $error("Serial clock not at idle level");
  chk_write_start: assert property (wr_tx && en && master && trig && state_r == M_IDLE // R1
    ##1 (en && master && trig) |=> state_r == M_RUN)
    else $error("Transmit write did not start transfer");
  chk_read_start: assert property (rd_rx && en && master && !trig && state_r == M_IDLE // R2
    ##1 (en && master && !trig) |=> state_r == M_RUN)
    else $error("Receive read did not start transfer");
  chk_ovf_set: assert property (deliver && rx_full_r && !rd_rx |=> ovf_r && rxirq_r) // R10
    else $error("Overflow not flagged");
  chk_rx_read_clear: assert property (rd_rx && !deliver // R12
    |=> !rx_full_r && !ovf_r && !rxirq_r) else $error("Receive read did not clear flags");
  chk_und_zero: assert property (load_ev && !tx_full_r && !ctl_r[`SPM_CTL_UNDREP] // R9
    |=> tsh_r == 8'h00 && und_r) else $error("Underflow did not send zeros");
  chk_und_repeat: assert property (load_ev && !tx_full_r && ctl_r[`SPM_CTL_UNDREP] // R20
    |=> tsh_r == $past(last_r)) else $error("Underflow did not repeat byte");
  chk_busy_set: assert property (wr_tx && !load_ev |=> busy_r && !txirq_r // R15
    ##1 (!tx_full_r || busy_r)) else $error("Busy not set by write");
  chk_disable_idle: assert property (!en |-> !sclk_oe_o && !mosi_oe_o && !miso_oe_o // R7
    ##1 state_r == M_IDLE) else $error("Disabled port still active");
  chk_bit_order: assert property (load_ev && tx_full_r // R3
    |=> mosi_o == (lsb ? $past(tx_data_r[0]) : $past(tx_data_r[7])))
    else $error("Wrong first bit");
  chk_keep_old: assert property (deliver && rx_full_r && !rd_rx && !ctl_r[`SPM_CTL_OVWR] // R22
    |=> $stable(rx_data_r)) else $error("Overflow byte not discarded");

  cov_master_done: cover property (state_r == M_RUN ##1 state_r == M_END);
  cov_slave_byte: cover property (s_act && deliver);
  cov_overflow: cover property (deliver && rx_full_r);
endmodule

/* File: spm_port_test.sv */
// Purpose: Self-checking bench for the serial port, master and slave roles
// Assumes: Peer model is the far slave; bench is the far master in slave mode
// Notes: Divider cut to 3 after the first transfer to keep the run short
`timescale 1ns/100ps
`include "spm_cfg.svh"
module spm_port_test;
  import spm_pkg::*;
  typedef struct packed {
    logic [15:0] ctl;
    logic [7:0] tx;
    logic [7:0] pb;
  } spm_row_type;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [31:0] addr = 32'h00000000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic m_sclk = 1'b0;
  logic m_mosi = 1'b0;
  logic m_ss_n = 1'b1;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic lsb = 1'b0;
  logic [7:0] ptx = 8'h00;
  logic [7:0] p_rx;
  logic [15:0] rdata;
  logic [15:0] d;
  logic sclk, sclk_oe, mosi, mosi_oe, miso, miso_oe, ss_n, ss_n_oe, p_miso;
  spm_state_type state;
  int miscompares = 0;
  int n_checks = 0;
  int len;
  // Undriven lines fall back to the bench master, or for miso to the peer model
  wire logic sclk_w = sclk_oe ? sclk : m_sclk;
  wire logic mosi_w = mosi_oe ? mosi : m_mosi;
  wire logic miso_w = miso_oe ? miso : p_miso;
  wire logic ss_w = ss_n_oe ? ss_n : m_ss_n;
  spm_row_type rows [8] = '{
    '{16'h0243, 8'hb4, 8'h5c}, '{16'h0247, 8'h1e, 8'h87},
    '{16'h024b, 8'hc8, 8'h31}, '{16'h024f, 8'h0f, 8'he2},
    '{16'h0263, 8'h4d, 8'ha6}, '{16'h0267, 8'hd2, 8'h19},
    '{16'h026b, 8'h38, 8'hb1}, '{16'h026f, 8'h7c, 8'h2a}
  };
  spm_port dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sclk_i(sclk_w), .sclk_o(sclk),
    .sclk_oe_o(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
    .miso_i(miso_w), .miso_o(miso), .miso_oe_o(miso_oe), .ss_n_i(ss_w),
    .ss_n_o(ss_n), .ss_n_oe_o(ss_n_oe), .state_o(state)
  );
  spm_peer peer (
    .sclk_i(sclk_w), .ss_n_i(ss_w), .mosi_i(mosi_w), .cpol_i(cpol), .cpha_i(cpha),
    .lsb_i(lsb), .tx_i(ptx), .miso_o(p_miso), .rx_o(p_rx)
  );
  always #20 ref_clk_i = ~ref_clk_i;
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    give_verdict();
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [31:0] a, input logic [15:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [31:0] a);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [15:0] e);
    rreg(a);
    chk(d, e);
  endtask
  task automatic set_mode(input logic [15:0] c);
    @(posedge ref_clk_i);
    cpol <= c[`SPM_CTL_CPOL];
    cpha <= c[`SPM_CTL_CPHA];
    lsb <= c[`SPM_CTL_LSB];
    m_sclk <= c[`SPM_CTL_CPOL];
    wreg(`SPM_OFS_CONTROL, c & 16'hffef);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(negedge ref_clk_i);
    while (state !== M_IDLE && n < 3000) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 3000) begin
      hang();
    end
  endtask
  task automatic half_len();
    logic s;
    int n;
    n = 0;
    @(negedge ref_clk_i);
    s = sclk;
    while (sclk === s && n < 600) begin
      @(negedge ref_clk_i);
      n++;
    end
    s = sclk;
    len = 0;
    while (sclk === s && len < 600) begin
      @(negedge ref_clk_i);
      len++;
    end
    if (n >= 600 || len >= 600) begin
      hang();
    end
  endtask
  task automatic go(input logic [7:0] b, input logic [7:0] pb);
    ptx <= pb;
    wreg(`SPM_OFS_TRANSMIT, {8'h00, b});
    wait_idle();
  endtask
  task automatic rdgo(input logic [15:0] e, input logic [7:0] pb);
    ptx <= pb;
    rchk(`SPM_OFS_RECEIVE, e);
    wait_idle();
  endtask
  // Mode 0 frame; slow edges since the pins pass two flip-flops
  task automatic sl_byte(input logic [7:0] b, input logic [7:0] e);
    logic [7:0] got;
    got = 8'h00;
    @(posedge ref_clk_i);
    m_ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      repeat (8) @(posedge ref_clk_i);
      got = {got[6:0], miso_w};
      m_mosi <= b[i];
      repeat (8) @(posedge ref_clk_i);
      m_sclk <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      m_sclk <= 1'b0;
    end
    repeat (8) @(posedge ref_clk_i);
    m_ss_n <= 1'b1;
    m_mosi <= ~b[0];
    chk({8'h00, got}, {8'h00, e});
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rchk(`SPM_OFS_STATUS, 16'h0000);
    rchk(`SPM_OFS_RECEIVE, 16'h0000);
    rchk(`SPM_OFS_DIVIDER, 16'h001b);
    rchk(`SPM_OFS_TRANSMIT, 16'h0000);
    rchk(32'hffff0a14, 16'h0000);
    set_mode(16'h0243);
    ptx <= 8'h96;
    wreg(`SPM_OFS_TRANSMIT, 16'h0069);
    half_len();
    chk(16'(len), 16'h001c);
    wait_idle();
    chk({8'h00, p_rx}, 16'h0069);
    rchk(`SPM_OFS_RECEIVE, 16'h0096);
    wreg(`SPM_OFS_DIVIDER, 16'h0003);
    rchk(`SPM_OFS_DIVIDER, 16'h0003);
    foreach (rows[i]) begin
      set_mode(rows[i].ctl);
      repeat (2) @(negedge ref_clk_i);
      chk({14'h0000, sclk, sclk_oe & mosi_oe}, {14'h0000, rows[i].ctl[3], 1'b1});
      go(rows[i].tx, rows[i].pb);
      chk({8'h00, p_rx}, {8'h00, rows[i].tx});
      rchk(`SPM_OFS_STATUS, 16'h001a);
      rchk(`SPM_OFS_RECEIVE, {8'h00, rows[i].pb});
      rchk(`SPM_OFS_STATUS, 16'h0002);
    end
    set_mode(16'h0283);
    rdgo({8'h00, rows[7].pb}, 8'h3c);
    chk({8'h00, p_rx}, {8'h00, rows[7].tx});
    set_mode(16'h0203);
    rdgo(16'h003c, 8'h3c);
    chk({8'h00, p_rx}, 16'h0000);
    rchk(`SPM_OFS_STATUS, 16'h001e);
    wreg(`SPM_OFS_TRANSMIT, 16'h0081);
    rchk(`SPM_OFS_STATUS, 16'h0019);
    rdgo(16'h003c, 8'hc3);
    chk({8'h00, p_rx}, 16'h0081);
    set_mode(16'h0243);
    go(8'h11, 8'h5a);
    rchk(`SPM_OFS_STATUS, 16'h003a);
    rchk(`SPM_OFS_RECEIVE, 16'h00c3);
    rchk(`SPM_OFS_STATUS, 16'h0002);
    set_mode(16'h0343);
    go(8'h22, 8'he1);
    go(8'h33, 8'h1e);
    rchk(`SPM_OFS_RECEIVE, 16'h001e);
    set_mode(16'h0342);
    rchk(`SPM_OFS_STATUS, 16'h0000);
    wreg(`SPM_OFS_TRANSMIT, 16'h0044);
    repeat (10) @(negedge ref_clk_i);
    chk({13'h0000, state, sclk_oe}, 16'h0000);
    set_mode(16'h0401);
    @(negedge ref_clk_i);
    chk({13'h0000, sclk_oe, mosi_oe, ss_n_oe}, 16'h0000);
    sl_byte(8'ha5, 8'h44);
    rreg(`SPM_OFS_STATUS);
    chk(d & 16'h0038, 16'h0018);
    rchk(`SPM_OFS_RECEIVE, 16'h00a5);
    set_mode(16'h0243);
    wreg(`SPM_OFS_TRANSMIT, 16'h0077);
    repeat (20) @(negedge ref_clk_i);
    chk({14'h0000, state}, 16'h0001);
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    @(negedge ref_clk_i);
    chk({13'h0000, state, ss_n}, 16'h0001);
    @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rchk(`SPM_OFS_STATUS, 16'h0000);
    rchk(`SPM_OFS_CONTROL, 16'h0000);
    give_verdict();
  end
endmodule
